// ### logic/tap_pkg.sv
// Shared constants and types for the boundary-scan test port
package tap_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int IR_W   = 4;    // Instruction register width
  localparam int BSR_W  = 24;   // Boundary chain length
  localparam int ID_W   = 32;   // Id and user code width
  localparam int ADDR_W = 7;    // Internal register address width
  localparam int DATA_W = 8;    // Internal register data width
  localparam int WR_W   = 15;   // Address plus data for a write
  localparam int PIN_N  = 11;   // Two-way pins in the chain
  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [3:0] INS_BYPASS = 4'h0;  // One-stage pass
  localparam logic [3:0] INS_SAMPLE = 4'h1;  // Sample and preload
  localparam logic [3:0] INS_IDCODE = 4'h2;  // Identification
  localparam logic [3:0] INS_USER   = 4'h3;  // User code
  localparam logic [3:0] INS_CLAMP  = 4'h4;  // Drive held cells
  localparam logic [3:0] INS_HIGHZ  = 4'h5;  // Float every pin
  localparam logic [3:0] INS_EXTEST = 4'h7;  // External test
  localparam logic [3:0] INS_IFSW   = 4'h8;  // Host interface switch
  localparam logic [3:0] INS_REGRD  = 4'h9;  // Register read
  localparam logic [3:0] INS_REGWR  = 4'hA;  // Register write
  localparam logic [3:0] IR_CAPT    = 4'h1;  // Instruction capture value
  // ----------------------------------------------------------------
  // Boundary cell positions
  // ----------------------------------------------------------------
  localparam int CELL_IN_ONLY = 6;  // Input-only cell
  localparam int CELL_OUT2    = 7;  // Extra output cell
  localparam int PIN_OUT2     = 7;  // Pin that owns the extra cell
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_e;
  typedef struct packed {
    logic             drive;      // Cells own the pins
    logic             float_all;  // Every pin released
    logic [BSR_W-1:0] cells;      // Held cell values
  } pin_ctl_s;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;      // Target address
    logic [DATA_W-1:0] data;      // Write data
  } reg_wr_s;
endpackage : tap_pkg

// ### logic/tap_port.sv
// Boundary-scan test port with pin override and register access
`timescale 1ns/10ps
module tap_port #(
  parameter logic [3:0]  ID_VERSION = 4'h1,     // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'h1234, // Arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h055   // Arbitrary value
) (
  input  wire logic                       clock,          // System clock
  input  wire logic                       rstn,           // Sync reset
  input  wire logic                       tck,            // Test clock
  input  wire logic                       tms,            // Mode select
  input  wire logic                       tdi,            // Test data in
  output logic                            tdo,            // Test data out
  output logic                            tdo_oe,         // Drives tdo
  input  wire logic [31:0]                nvm_user_code,  // Memory bytes
  input  wire logic [tap_pkg::PIN_N-1:0]  pad_in,         // Pin levels
  output logic      [tap_pkg::PIN_N-1:0]  pad_out,        // Pin drive
  output logic      [tap_pkg::PIN_N-1:0]  pad_oe,         // Pin enables
  input  wire logic                       host_if_pin_3,  // Input pin
  input  wire logic [tap_pkg::PIN_N-1:0]  core_out,       // Core drive
  input  wire logic [tap_pkg::PIN_N-1:0]  core_oe,        // Core enables
  output logic      [tap_pkg::PIN_N-1:0]  core_in,        // Pins to core
  output logic                            host_if_off,    // Host if off
  output logic      [tap_pkg::ADDR_W-1:0] reg_addr,       // Reg address
  output logic      [tap_pkg::DATA_W-1:0] reg_wdata,      // Write data
  output logic                            reg_we,         // Write pulse
  input  wire logic [tap_pkg::DATA_W-1:0] reg_rdata       // Read data
);
  import tap_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Data cell of a two-way pin; its control cell sits just above
  function automatic int data_cell(input int pin);
    data_cell = (pin < 8) ? 22 - 2 * pin : 4 - 2 * (pin - 8);
  endfunction : data_cell

  // Top bit index of the data chain picked by an instruction
  function automatic logic [4:0] dr_top(input logic [3:0] ins);
    unique case (ins)
      INS_SAMPLE, INS_EXTEST: dr_top = 5'(BSR_W - 1);
      INS_IDCODE, INS_USER:   dr_top = 5'(ID_W - 1);
      INS_REGRD:              dr_top = 5'(DATA_W - 1);
      INS_REGWR:              dr_top = 5'(WR_W - 1);
      default:                dr_top = 5'h0;
    endcase
  endfunction : dr_top

  // ----------------------------------------------------------------
  // Test clock domain: reset and input synchronisers
  // ----------------------------------------------------------------
  logic        trst_m_r, trstn_r;     // Reset carried into test domain
  logic [31:0] user_m_r, user_r;      // User code, quasi-static
  logic [PIN_N:0] pin_m_r, pin_r;     // Pins plus input-only pin
  logic [DATA_W-1:0] rd_hold_r, rd_hold_nxt;  // Held on system clock
  logic [DATA_W-1:0] rd_m_r, rd_r;    // Read data from system side

  // Two flops on every level entering the test domain
  always_ff @(posedge tck)
  begin
    trst_m_r <= rstn;
    trstn_r  <= trst_m_r;
    user_m_r <= nvm_user_code;
    user_r   <= user_m_r;
    pin_m_r  <= {host_if_pin_3, pad_in};
    pin_r    <= pin_m_r;
    rd_m_r   <= rd_hold_r;
    rd_r     <= rd_m_r;
  end

  // ----------------------------------------------------------------
  // Controller and chains
  // ----------------------------------------------------------------
  tap_state_e  st_r, st_nxt;            // Controller state
  logic [3:0]  ir_r, ir_nxt;            // Active instruction
  logic [3:0]  ir_sh_r, ir_sh_nxt;      // Instruction shift chain
  logic [31:0] dr_sh_r, dr_sh_nxt;      // Shared data shift chain
  logic [BSR_W-1:0] upd_r, upd_nxt;     // Boundary update latches
  logic        if_off_r, if_off_nxt;    // Host interface switched off
  logic [ADDR_W-1:0] addr_r, addr_nxt;  // Current read address
  reg_wr_s     wr_r, wr_nxt;            // Held write request
  logic        wr_tgl_r, wr_tgl_nxt;    // Write event toggle
  logic [4:0]  top;                     // Chain top for this code

  // Next state, chain moves and update actions
  always_comb
  begin
    st_nxt     = st_r;
    ir_nxt     = ir_r;
    ir_sh_nxt  = ir_sh_r;
    dr_sh_nxt  = dr_sh_r;
    upd_nxt    = upd_r;
    if_off_nxt = if_off_r;
    addr_nxt   = addr_r;
    wr_nxt     = wr_r;
    wr_tgl_nxt = wr_tgl_r;
    top        = dr_top(ir_r);
    // Move only on the sampled mode-select level
    unique case (st_r)
      TLR:    st_nxt = tms ? TLR    : RTI;
      RTI:    st_nxt = tms ? SEL_DR : RTI;
      SEL_DR: st_nxt = tms ? SEL_IR : CAP_DR;
      CAP_DR: st_nxt = tms ? EX1_DR : SH_DR;
      SH_DR:  st_nxt = tms ? EX1_DR : SH_DR;
      EX1_DR: st_nxt = tms ? UPD_DR : PA_DR;
      PA_DR:  st_nxt = tms ? EX2_DR : PA_DR;
      EX2_DR: st_nxt = tms ? UPD_DR : SH_DR;
      UPD_DR: st_nxt = tms ? SEL_DR : RTI;
      SEL_IR: st_nxt = tms ? TLR    : CAP_IR;
      CAP_IR: st_nxt = tms ? EX1_IR : SH_IR;
      SH_IR:  st_nxt = tms ? EX1_IR : SH_IR;
      EX1_IR: st_nxt = tms ? UPD_IR : PA_IR;
      PA_IR:  st_nxt = tms ? EX2_IR : PA_IR;
      EX2_IR: st_nxt = tms ? UPD_IR : SH_IR;
      UPD_IR: st_nxt = tms ? SEL_DR : RTI;
    endcase
    unique case (st_r)
      TLR:    ir_nxt = INS_IDCODE;
      CAP_IR: ir_sh_nxt = IR_CAPT;
      SH_IR:  ir_sh_nxt = {tdi, ir_sh_r[3:1]};
      UPD_IR: ir_nxt = ir_sh_r;
      CAP_DR:
      begin
        dr_sh_nxt = '0;
        unique case (ir_r)
          INS_SAMPLE, INS_EXTEST:
          begin
            // Data cells and the input-only cell see pins, others echo their latches
            dr_sh_nxt[BSR_W-1:0] = upd_r;
            for (int p = 0; p < PIN_N; p++)
              dr_sh_nxt[data_cell(p)] = pin_r[p];
            dr_sh_nxt[CELL_IN_ONLY] = pin_r[PIN_N];
          end
          INS_IDCODE:
            dr_sh_nxt = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
          INS_USER:  dr_sh_nxt = user_r;
          INS_REGRD:
            dr_sh_nxt[DATA_W-1:0] = if_off_r ? rd_r : '0;
          INS_REGWR:
          begin
            dr_sh_nxt = dr_sh_r;
            if (if_off_r)
            begin
              wr_nxt     = dr_sh_r[WR_W-1:0];
              wr_tgl_nxt = ~wr_tgl_r;
            end
          end
          default: dr_sh_nxt = '0;
        endcase
      end
      SH_DR:
      begin
        // Shift toward bit 0, new bit enters at the chain top
        dr_sh_nxt      = {1'b0, dr_sh_r[31:1]};
        dr_sh_nxt[top] = tdi;
      end
      UPD_DR:
        unique case (ir_r)
          INS_SAMPLE, INS_EXTEST: upd_nxt = dr_sh_r[BSR_W-1:0];
          INS_IFSW:  if_off_nxt = dr_sh_r[0];
          INS_REGRD: addr_nxt = dr_sh_r[ADDR_W-1:0];
          default:   upd_nxt = upd_r;
        endcase
      default: ir_nxt = ir_r;
    endcase
  end

  // State only moves on test clock edges, so a stopped clock holds it
  always_ff @(posedge tck)
  begin
    if (!trstn_r)
    begin
      st_r     <= TLR;
      ir_r     <= INS_IDCODE;
      ir_sh_r  <= IR_CAPT;
      dr_sh_r  <= '0;
      upd_r    <= '0;
      if_off_r <= 1'b0;
      addr_r   <= '0;
      wr_r     <= '0;
      wr_tgl_r <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      ir_r     <= ir_nxt;
      ir_sh_r  <= ir_sh_nxt;
      dr_sh_r  <= dr_sh_nxt;
      upd_r    <= upd_nxt;
      if_off_r <= if_off_nxt;
      addr_r   <= addr_nxt;
      wr_r     <= wr_nxt;
      wr_tgl_r <= wr_tgl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Serial output on the falling edge
  // ----------------------------------------------------------------
  logic tdo_nxt, tdo_oe_nxt;  // Output values for the next fall

  // Chain bit 0 while shifting, quiet otherwise
  always_comb
  begin
    tdo_oe_nxt = (st_r == SH_IR) || (st_r == SH_DR);
    tdo_nxt    = (st_r == SH_IR) ? ir_sh_r[0] :
                 (st_r == SH_DR) ? dr_sh_r[0] : 1'b0;
  end

  // Falling edge gives the next device a full half cycle of setup
  always_ff @(negedge tck)
  begin
    if (!trstn_r)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo    <= tdo_nxt;
      tdo_oe <= tdo_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  pin_ctl_s    ctl_t, ctl_m_r, ctl_r;         // Pin control crossing
  logic [ADDR_W:0] off_m_r, off_r;            // Switch and read address
  reg_wr_s     wr_m_r, wr_s_r;                // Write request crossing
  logic [2:0]  tgl_r;                         // Toggle sync plus edge
  logic [PIN_N-1:0] cin_m_r;                  // Pin sync first stage
  logic [PIN_N-1:0] pad_out_nxt, pad_oe_nxt;  // Pin drive next values
  logic [ADDR_W-1:0] reg_addr_nxt;            // Address next value

  // Cells take the pins under extest and clamp, highz floats all
  assign ctl_t = '{drive:     (ir_r == INS_EXTEST) || (ir_r == INS_CLAMP),
                   float_all: (ir_r == INS_HIGHZ),
                   cells:     upd_r};

  // Levels are quasi-static, so two flops per bit are enough
  always_ff @(posedge clock)
  begin
    ctl_m_r <= ctl_t;
    ctl_r   <= ctl_m_r;
    off_m_r <= {if_off_r, addr_r};
    off_r   <= off_m_r;
    wr_m_r  <= wr_r;
    wr_s_r  <= wr_m_r;
    cin_m_r <= pad_in;
  end

  // Pin drive, read address and read capture
  always_comb
  begin
    for (int p = 0; p < PIN_N; p++)
    begin
      pad_out_nxt[p] = core_out[p];
      pad_oe_nxt[p]  = core_oe[p];
      if (ctl_r.float_all)
        pad_oe_nxt[p] = 1'b0;
      else if (ctl_r.drive)
      begin
        pad_out_nxt[p] = ctl_r.cells[data_cell(p)];
        pad_oe_nxt[p]  = ctl_r.cells[data_cell(p) + 1];
      end
    end
    if (ctl_r.drive && !ctl_r.float_all)
      pad_out_nxt[PIN_OUT2] = ctl_r.cells[CELL_OUT2];
    reg_addr_nxt = (tgl_r[2] ^ tgl_r[1]) ? wr_s_r.addr : off_r[ADDR_W-1:0];
    rd_hold_nxt  = reg_we ? rd_hold_r : reg_rdata;
  end

  // Registered outputs; the toggle edge marks one write
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tgl_r       <= '0;
      pad_out     <= '0;
      pad_oe      <= '0;
      core_in     <= '0;
      host_if_off <= 1'b0;
      reg_addr    <= '0;
      reg_wdata   <= '0;
      reg_we      <= 1'b0;
      rd_hold_r   <= '0;
    end
    else
    begin
      tgl_r       <= {tgl_r[1:0], wr_tgl_r};
      pad_out     <= pad_out_nxt;
      pad_oe      <= pad_oe_nxt;
      core_in     <= cin_m_r;
      host_if_off <= off_r[ADDR_W];
      reg_addr    <= reg_addr_nxt;
      reg_wdata   <= wr_s_r.data;
      reg_we      <= tgl_r[2] ^ tgl_r[1];
      rd_hold_r   <= rd_hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tms_reset: assert property (@(posedge tck) disable iff (!trstn_r)
    tms [*5] |=> st_r == TLR) else $error("no reset after five highs");
  a_reset_ins: assert property (@(posedge tck) disable iff (!trstn_r)
    st_r == TLR |=> ir_r == INS_IDCODE) else $error("reset lost id code");
  a_idle_hold: assert property (@(posedge tck) disable iff (!trstn_r)
    (st_r == RTI && !tms) |=> st_r == RTI) else $error("idle not held");
  a_bypass_one: assert property (@(posedge tck)
    disable iff (!trstn_r)
    (st_r == SH_DR && ir_r == INS_BYPASS) |=> dr_sh_r[0] == $past(tdi))
    else $error("bypass stage wrong");
  a_id_lsb: assert property (@(posedge tck) disable iff (!trstn_r)
    (st_r == CAP_DR && ir_r == INS_IDCODE) |=> dr_sh_r[0] && 
    dr_sh_r[31:28] == ID_VERSION) else $error("id value wrong");
  a_switch_upd: assert property (@(posedge tck)
    disable iff (!trstn_r)
    (st_r == UPD_DR && ir_r == INS_IFSW) |=> if_off_r == $past(dr_sh_r[0]))
    else $error("switch not taken");
  a_tdo_quiet: assert property (@(negedge tck) disable iff (!trstn_r)
    !(st_r == SH_DR || st_r == SH_IR) |=> !tdo_oe) else $error("tdo active");
  a_tdo_bit: assert property (@(negedge tck) disable iff (!trstn_r)
    (st_r == SH_IR) |=> tdo == $past(ir_sh_r[0])) else $error("tdo bit wrong");
  a_we_pulse: assert property (@(posedge clock) disable iff (!rstn)
    reg_we |=> !reg_we) else $error("write pulse too long");
endmodule : tap_port

// ### sim/tap_ctrl_model.sv
// Test controller model: makes the test clock and drives mode and data
`timescale 1ns/10ps
module tap_ctrl_model (
  output logic      tck,  // Test clock, still between frames
  output logic      tms,  // Mode select
  output logic      tdi,  // Test data in
  input  wire logic tdo   // Test data out
);
  logic sampled;  // Last data out seen on a rising edge
  // Lines rest at their pull-up level, clock parked low
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One clock cycle; inputs change only while the clock is low
  task automatic move(input logic t, input logic d);
    tms = t;
    tdi = d;
    #3 tck = 1'b1;
    sampled = tdo;
    #3 tck = 1'b0;
  endtask : move
  // Mode select held high; five cycles are enough to reach reset
  task automatic tlr(input int n);
    repeat (n) move(1'b1, 1'b1);
  endtask : tlr
  // Full scan from idle back to idle, lsb first
  task automatic shift(input logic ir, input int n,
                       input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    move(1'b1, 1'b1);
    if (ir) move(1'b1, 1'b1);
    move(1'b0, 1'b1);
    move(1'b0, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      move(i == n - 1, din[i]);
      dout[i] = sampled;
    end
    move(1'b1, 1'b1);
    move(1'b0, 1'b1);
  endtask : shift
endmodule : tap_ctrl_model

// ### sim/tb.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module tb;
  import tap_pkg::*;
  localparam logic [3:0]  VER  = 4'h3;     // Arbitrary value
  localparam logic [15:0] PART = 16'h5A6C; // Arbitrary value
  localparam logic [10:0] MAKR = 11'h123;  // Arbitrary value
  logic              clock = 1'b0;  // System clock
  logic              rstn  = 1'b0;  // Sync reset
  logic              tck, tms, tdi;  // Test port lines
  logic              tdo, tdo_oe;    // Test data out
  logic [31:0]       nvm = 32'hC4A71E59;  // User code bytes
  logic [PIN_N-1:0]  pad_in = 11'h2B6;    // Pin levels
  logic [PIN_N-1:0]  pad_out, pad_oe, core_in;  // Pin side
  logic [PIN_N-1:0]  core_out = 11'h4D3;  // Core drive
  logic [PIN_N-1:0]  core_oe = 11'h3F0;   // Core enables
  logic              pin3 = 1'b1;         // Input-only pin
  logic              host_if_off, reg_we;  // Access side
  logic [6:0]        reg_addr;   // Register address
  logic [7:0]        reg_wdata;  // Write data
  logic [7:0]        mem [128];  // Internal registers stand-in
  int                err_count = 0;  // Mismatches
  int                tests_run = 0;  // Comparisons
  int                wr_count = 0;   // Write pulses seen
  logic [14:0]       wr_last = '0;   // Address and data of last write
  always #4 clock = ~clock;
  tap_ctrl_model u_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  tap_port #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKR)) u_dut (
    .clock(clock), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .nvm_user_code(nvm), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .host_if_pin_3(pin3),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .host_if_off(host_if_off), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(mem[reg_addr]));
  // Register file stand-in; preset pattern so reads are traceable
  initial
  begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  always @(posedge clock)
  begin
    if (reg_we === 1'b1)
    begin
      mem[reg_addr] <= reg_wdata;
      wr_count <= wr_count + 1;
      wr_last <= {reg_addr, reg_wdata};
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("errors %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Load an instruction; the capture pattern must come out first
  task automatic run_ir(input logic [3:0] code);
    logic [31:0] d;
    u_ctrl.shift(1'b1, 4, 32'(code), d);
    check(32'(d[3:0]), 32'(IR_CAPT));
  endtask : run_ir
  // Data cell of pin k; its control cell sits just above
  function automatic int dcell(input int k);
    return (k <= 7) ? 22 - 2 * k : (10 - k) * 2;
  endfunction : dcell
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_user();
    logic [31:0] d;
    u_ctrl.shift(1'b0, 32, 32'h0, d);
    check(d, {VER, PART, MAKR, 1'b1});
    run_ir(INS_USER);
    #400;  // Clock parked long; state must survive
    u_ctrl.shift(1'b0, 32, 32'h0, d);
    check(d, nvm);
  endtask : t_user
  // Listed bypass plus unlisted codes, one stage of delay each
  task automatic t_bypass();
    logic [3:0]  codes [4] = '{INS_BYPASS, 4'h6, 4'hB, 4'hF};
    logic [31:0] d;
    foreach (codes[i])
    begin
      run_ir(codes[i]);
      u_ctrl.shift(1'b0, 8, 32'hB5, d);
      check(d, 32'h6A);
      check(32'(tdo_oe), 32'h0);
    end
  endtask : t_bypass
  // Abort mid-shift by holding mode select; id must come back
  task automatic t_tlr();
    logic [31:0] d;
    u_ctrl.move(1'b1, 1'b1);
    u_ctrl.move(1'b0, 1'b1);
    u_ctrl.move(1'b0, 1'b1);
    u_ctrl.tlr(5);
    u_ctrl.move(1'b0, 1'b1);
    u_ctrl.shift(1'b0, 32, 32'h0, d);
    check(d, {VER, PART, MAKR, 1'b1});
  endtask : t_tlr
  task automatic t_boundary();
    logic [31:0]      d;
    logic [23:0]      p = 24'h6BD2A9;
    logic [PIN_N-1:0] oe_x, out_x;
    int               c;
    run_ir(INS_EXTEST);
    u_ctrl.shift(1'b0, 24, 32'(p), d);
    #80;
    for (int k = 0; k < PIN_N; k++)
    begin
      c = dcell(k);
      oe_x[k] = p[c + 1];
      out_x[k] = p[(k == PIN_OUT2) ? CELL_OUT2 : c];
      check(32'(d[c]), 32'(pad_in[k]));
    end
    check(32'(d[CELL_IN_ONLY]), 32'(pin3));
    check(32'({pad_oe, pad_out}), 32'({oe_x, out_x}));
    run_ir(INS_CLAMP);
    #80;
    check(32'({pad_oe, pad_out}), 32'({oe_x, out_x}));
    run_ir(INS_HIGHZ);
    #80;
    check(32'(pad_oe), 32'h0);
    run_ir(INS_SAMPLE);
    // Preload under sample must not reach the pins
    u_ctrl.shift(1'b0, 24, 32'(~p), d);
    #80;
    check(32'(d[CELL_IN_ONLY]), 32'(pin3));
    check(32'(d[23]), 32'(p[23]));
    check(32'({pad_oe, pad_out}), 32'({core_oe, core_out}));
    check(32'(core_in), 32'(pad_in));
  endtask : t_boundary
  // Refused write, switch, write, then chained reads
  task automatic t_regs();
    logic [31:0] d;
    run_ir(INS_REGWR);
    repeat (2) u_ctrl.shift(1'b0, 15, 32'h169E, d);
    #80;
    check(32'(wr_count), 32'h0);
    run_ir(INS_IFSW);
    u_ctrl.shift(1'b0, 1, 32'h1, d);
    #80;
    check(32'(host_if_off), 32'h1);
    run_ir(INS_REGWR);
    u_ctrl.shift(1'b0, 15, {17'h0, 7'h2C, 8'h9E}, d);
    #80;
    u_ctrl.shift(1'b0, 15, 32'h0, d);
    #80;
    // First capture after the switch also writes the stale one-bit chain
    check({wr_count[15:0], 1'b0, wr_last}, 32'h2_2C9E);
    check(32'(mem[0]), 32'h1);
    run_ir(INS_REGRD);
    u_ctrl.shift(1'b0, 8, 32'h7F, d);
    #80;
    check(32'(reg_addr), 32'h7F);
    u_ctrl.shift(1'b0, 8, 32'h2C, d);
    #80;
    check(d, 32'(8'h7F ^ 8'h5A));
    #80;
    u_ctrl.shift(1'b0, 8, 32'h2C, d);
    check(d, 32'h9E);
  endtask : t_regs
  // Main sequence; test clock runs through reset as required
  initial
  begin
    fork
      repeat (12) @(posedge clock);
      u_ctrl.tlr(16);
    join
    @(posedge clock);
    #1 rstn = 1'b1;
    u_ctrl.tlr(5);
    u_ctrl.move(1'b0, 1'b1);
    check(32'({host_if_off, tdo_oe}), 32'h0);
    t_user();
    t_bypass();
    t_tlr();
    t_boundary();
    t_regs();
    final_report();
  end
  // Watchdog well beyond the expected few microseconds
  initial
  begin
    #100000;
    err_count++;
    final_report();
  end
endmodule : tb
